//--- acdc_defs.svh
// Register offsets, field positions, reset values and timing counts for the codec digital control.
// Assumes an APB slave with 32-bit data clocked by pclk at 50 MHz.
// How it works
// - Coupling bits 7-6: 00 independent, 10/11 left gain both, 01 right gain both.
// - Left output gain is five bits 4-0, reset value 01010.
// - Right output gain is five bits 4-0, upper three bits unused.
// - DAC chopper bit 7 and ADC chopper bit 3 reset to one.
// - Flow adapter enables, bit 6 DAC and bit 4 ADC, reset to one.
// - Bias, noise-transfer test and auto-reset bits reset to zero.
// - Instability flag bit 0 set by hardware, cleared by writing zero.
// - Each frame sync is one clock cycle high per frame.
// - Serial data starts one clock cycle after the frame sync rises.
// - Left sample first, then right, each most significant bit first.
// - Right follows left with no gap, word length 16, 18, 20 or 24.
// - Mute input is synchronised on clock rising edges before use.
// - Mute high ramps gain to silence over 19.97 ms, then outputs zero.
// - Mute low ramps gain back to unity over 19.97 ms, then normal.
// - Ten standby bits; master standby powers down all, then sleep.
// - Two test standby bits exist apart from the ten functional ones; the standby register here holds only the ten.
// - Record needs master, sleep, ADC standby low plus chosen source standby low.
// - In playback, headphone/line select 0 routes headphone, 1 routes line out.
`ifndef ACDC_DEFS_SVH
`define ACDC_DEFS_SVH
`define ACDC_OFF_OGL       12'h000
`define ACDC_OFF_OGR       12'h004
`define ACDC_OFF_AIG       12'h008
`define ACDC_OFF_TCA       12'h00C
`define ACDC_OFF_TCB       12'h010
`define ACDC_OFF_STBY      12'h014
`define ACDC_OFF_AUDIO     12'h018
`define ACDC_OFF_STATUS    12'h01C
`define ACDC_OFF_DACL      12'h020
`define ACDC_OFF_DACR      12'h024
`define ACDC_OFF_ADCL      12'h028
`define ACDC_OFF_ADCR      12'h02C
`define ACDC_RST_OGL       8'h0A
`define ACDC_RST_OGR       8'h0A
`define ACDC_RST_AIG       8'h00
`define ACDC_RST_TCA       8'h00
`define ACDC_RST_TCB       8'hD8
`define ACDC_RST_STBY      10'h0B1
`define ACDC_MUTE_RAMP_NS  64'd19970000
`define ACDC_CLK_NS        64'd20
`define ACDC_RAMP_CYCLES   ((`ACDC_MUTE_RAMP_NS) / (`ACDC_CLK_NS))
`define ACDC_FRAME_BITS    8'd64
`endif

//--- acdc_pkg.sv
// Types shared by the codec digital control.
// Assumes acdc_defs.svh supplies the numeric constants.
package acdc_pkg;
    typedef enum logic [1:0] {
        ACDC_NORMAL = 2'b00,
        ACDC_DOWN   = 2'b01,
        ACDC_MUTED  = 2'b11,
        ACDC_UP     = 2'b10
    } acdc_mute_t;
    typedef enum logic [1:0] {
        ACDC_WL16 = 2'b00,
        ACDC_WL18 = 2'b01,
        ACDC_WL20 = 2'b10,
        ACDC_WL24 = 2'b11
    } acdc_wlen_t;
endpackage : acdc_pkg

//--- acdc_top.sv
// Codec digital control: gain and test registers, standby decoding, soft mute and serial audio framing.
// Assumes an APB master on pclk; mute_in, adc_serial_audio_line_in and adc_instability_in are asynchronous pins.
`timescale 1ns/1ps
`include "acdc_defs.svh"
module acdc_top
    import acdc_pkg::*;
#(
    parameter int unsigned RAMP_CYCLES = 32'(`ACDC_RAMP_CYCLES)
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        mute_in,
    input  wire logic        adc_instability_in,
    input  wire logic        adc_serial_audio_line_in,
    output logic             dac_frame_sync_pulse,
    output logic             dac_serial_audio_line,
    output logic             adc_frame_sync_pulse,
    output logic [4:0]       eff_left_gain,
    output logic [4:0]       eff_right_gain,
    output logic [15:0]      digital_gain_stage,
    output logic             power_down,
    output logic             sleep_mode,
    output logic             record_ok,
    output logic             headphone_route,
    output logic             line_out_route,
    output logic             clock_stop_ok
);
    localparam logic [15:0] GAIN_MAX = 16'hFFFF;

    logic [7:0]  ogl_reg;
    logic [7:0]  ogr_reg;
    logic [7:0]  aig_reg;
    logic [7:0]  tca_reg;
    logic [7:0]  tcb_reg;
    logic [9:0]  stby_reg;
    logic [1:0]  wlen_reg;
    logic [23:0] dacl_reg;
    logic [23:0] dacr_reg;
    logic [23:0] adcl_reg;
    logic [23:0] adcr_reg;
    logic [2:0]  mute_sync;
    logic [1:0]  unst_sync;
    logic [1:0]  sdi_sync;
    acdc_mute_t  mute_state;
    logic [31:0] ramp_cnt;
    logic [7:0]  bit_cnt;
    logic [4:0]  wbits;
    logic [47:0] tx_shift;
    logic [47:0] rx_shift;
    logic [47:0] left_word;
    logic [47:0] right_word;
    logic        wr_en;
    logic        rd_en;
    logic        mapped;
    logic [31:0] rd_mux;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;

    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            `ACDC_OFF_OGL:    rd_mux = {24'h0, ogl_reg[7:6], 1'b0, ogl_reg[4:0]};
            `ACDC_OFF_OGR:    rd_mux = {27'h0, ogr_reg[4:0]};
            `ACDC_OFF_AIG:    rd_mux = {24'h0, aig_reg};
            `ACDC_OFF_TCA:    rd_mux = {24'h0, tca_reg};
            `ACDC_OFF_TCB:    rd_mux = {24'h0, tcb_reg};
            `ACDC_OFF_STBY:   rd_mux = {22'h0, stby_reg};
            `ACDC_OFF_AUDIO:  rd_mux = {30'h0, wlen_reg};
            `ACDC_OFF_STATUS: rd_mux = {28'h0, mute_state, mute_sync[2], 1'b0};
            `ACDC_OFF_DACL:   rd_mux = {8'h0, dacl_reg};
            `ACDC_OFF_DACR:   rd_mux = {8'h0, dacr_reg};
            `ACDC_OFF_ADCL:   rd_mux = {8'h0, adcl_reg};
            `ACDC_OFF_ADCR:   rd_mux = {8'h0, adcr_reg};
            default:          mapped = 1'b0;
        endcase
    end

    // No wait states: data is registered in setup and presented with pready in the first access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (rd_en) begin
                prdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ogl_reg  <= `ACDC_RST_OGL;
            ogr_reg  <= `ACDC_RST_OGR;
            aig_reg  <= `ACDC_RST_AIG;
            tca_reg  <= `ACDC_RST_TCA;
            stby_reg <= `ACDC_RST_STBY;
            wlen_reg <= ACDC_WL16;
            dacl_reg <= 24'h00_0000;
            dacr_reg <= 24'h00_0000;
        end else if (wr_en && pready && pstrb[0]) begin
            case (paddr)
                `ACDC_OFF_OGL:   ogl_reg  <= {pwdata[7:6], 1'b0, pwdata[4:0]};
                `ACDC_OFF_OGR:   ogr_reg  <= {3'b000, pwdata[4:0]};
                `ACDC_OFF_AIG:   aig_reg  <= pwdata[7:0];
                `ACDC_OFF_TCA:   tca_reg  <= pwdata[7:0];
                `ACDC_OFF_STBY:  stby_reg <= {pstrb[1] ? pwdata[9:8] : stby_reg[9:8], pwdata[7:0]};
                `ACDC_OFF_AUDIO: wlen_reg <= pwdata[1:0];
                `ACDC_OFF_DACL:  dacl_reg <= pwdata[23:0];
                `ACDC_OFF_DACR:  dacr_reg <= pwdata[23:0];
                default:         ;
            endcase
        end
    end

    // Bit 0 is sticky: a new instability event wins over a software clear in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tcb_reg <= `ACDC_RST_TCB;
        end else begin
            if (wr_en && pready && pstrb[0] && paddr == `ACDC_OFF_TCB) begin
                tcb_reg[7:1] <= pwdata[7:1];
                tcb_reg[0]   <= unst_sync[1] | (tcb_reg[0] & pwdata[0]);
            end else if (unst_sync[1]) begin
                tcb_reg[0] <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mute_sync <= 3'b000;
            unst_sync <= 2'b00;
            sdi_sync  <= 2'b00;
        end else begin
            mute_sync <= {mute_sync[1:0], mute_in};
            unst_sync <= {unst_sync[0], adc_instability_in};
            sdi_sync  <= {sdi_sync[0], adc_serial_audio_line_in};
        end
    end

    // Soft mute ramp; the gain slope is linear in cycles across the ramp time.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mute_state <= ACDC_NORMAL;
            ramp_cnt   <= 32'd0;
        end else begin
            case (mute_state)
                ACDC_NORMAL: begin
                    ramp_cnt <= 32'd0;
                    if (mute_sync[2]) begin
                        mute_state <= ACDC_DOWN;
                    end
                end
                ACDC_DOWN: begin
                    if (ramp_cnt >= RAMP_CYCLES - 1) begin
                        mute_state <= ACDC_MUTED;
                        ramp_cnt   <= 32'd0;
                    end else begin
                        ramp_cnt <= ramp_cnt + 32'd1;
                    end
                end
                ACDC_MUTED: begin
                    if (!mute_sync[2]) begin
                        mute_state <= ACDC_UP;
                    end
                end
                ACDC_UP: begin
                    if (ramp_cnt >= RAMP_CYCLES - 1) begin
                        mute_state <= ACDC_NORMAL;
                        ramp_cnt   <= 32'd0;
                    end else begin
                        ramp_cnt <= ramp_cnt + 32'd1;
                    end
                end
                default: mute_state <= ACDC_NORMAL;
            endcase
        end
    end

    function automatic logic [15:0] ramp_gain(input logic [31:0] cnt);
        logic [47:0] prod;
        prod = 48'(cnt) * 48'(GAIN_MAX);
        return 16'(prod / 48'(RAMP_CYCLES));
    endfunction : ramp_gain

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            digital_gain_stage <= GAIN_MAX;
        end else begin
            case (mute_state)
                ACDC_NORMAL: digital_gain_stage <= GAIN_MAX;
                ACDC_DOWN:   digital_gain_stage <= GAIN_MAX - ramp_gain(ramp_cnt);
                ACDC_MUTED:  digital_gain_stage <= 16'h0000;
                ACDC_UP:     digital_gain_stage <= ramp_gain(ramp_cnt);
                default:     digital_gain_stage <= GAIN_MAX;
            endcase
        end
    end

    always_comb begin
        case (acdc_wlen_t'(wlen_reg))
            ACDC_WL16: wbits = 5'd16;
            ACDC_WL18: wbits = 5'd18;
            ACDC_WL20: wbits = 5'd20;
            default:   wbits = 5'd24;
        endcase
    end

    // Right-sample bits above the word length are masked so they cannot spill into the left slot.
    always_comb begin
        left_word  = {24'h0, dacl_reg} << (6'd48 - 6'(wbits));
        right_word = ({24'h0, dacr_reg} & ((48'h1 << wbits) - 48'h1)) << (6'd48 - 6'(wbits) - 6'(wbits));
    end

    // Fixed 64-cycle frame; both samples are packed MSB first with no gap.
    // Muted frames send zeros, so the converter keeps running on silence.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt               <= 8'd0;
            dac_frame_sync_pulse  <= 1'b0;
            adc_frame_sync_pulse  <= 1'b0;
            dac_serial_audio_line <= 1'b0;
            tx_shift              <= 48'h0;
        end else begin
            bit_cnt              <= (bit_cnt == `ACDC_FRAME_BITS - 8'd1) ? 8'd0 : bit_cnt + 8'd1;
            dac_frame_sync_pulse <= (bit_cnt == 8'd0);
            adc_frame_sync_pulse <= (bit_cnt == 8'd0);
            if (bit_cnt == 8'd0) begin
                if (mute_state == ACDC_MUTED) begin
                    tx_shift <= 48'h0;
                end else begin
                    tx_shift <= left_word | right_word;
                end
                dac_serial_audio_line <= 1'b0;
            end else begin
                dac_serial_audio_line <= tx_shift[47];
                tx_shift              <= {tx_shift[46:0], 1'b0};
            end
        end
    end

    // Receive: the sync pipes are two cycles, so sampling is offset by two counts.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_shift <= 48'h0;
            adcl_reg <= 24'h00_0000;
            adcr_reg <= 24'h00_0000;
        end else begin
            if (bit_cnt >= 8'd4 && bit_cnt < 8'd4 + {2'b0, wbits, 1'b0}) begin
                rx_shift <= {rx_shift[46:0], sdi_sync[1]};
            end
            if (bit_cnt == 8'd4 + {2'b0, wbits, 1'b0}) begin
                adcl_reg <= 24'(rx_shift >> wbits);
                adcr_reg <= 24'(rx_shift & ((48'h1 << wbits) - 48'h1));
                rx_shift <= 48'h0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eff_left_gain   <= 5'h0A;
            eff_right_gain  <= 5'h0A;
            power_down      <= 1'b0;
            sleep_mode      <= 1'b0;
            record_ok       <= 1'b0;
            headphone_route <= 1'b0;
            line_out_route  <= 1'b0;
            clock_stop_ok   <= 1'b0;
        end else begin
            case (ogl_reg[7:6])
                2'b00: begin
                    eff_left_gain  <= ogl_reg[4:0];
                    eff_right_gain <= ogr_reg[4:0];
                end
                2'b01: begin
                    eff_left_gain  <= ogr_reg[4:0];
                    eff_right_gain <= ogr_reg[4:0];
                end
                default: begin
                    eff_left_gain  <= ogl_reg[4:0];
                    eff_right_gain <= ogl_reg[4:0];
                end
            endcase
            // Standby bits: 9 master, 8 sleep, 7 dac, 6 out, 5 hp/line, 4 adc, 3 mic, 2 line1, 1 line2, 0 mixer in.
            power_down    <= stby_reg[9];
            sleep_mode    <= !stby_reg[9] && stby_reg[8];
            clock_stop_ok <= stby_reg[9] || stby_reg[8];
            record_ok     <= !stby_reg[9] && !stby_reg[8] && !stby_reg[4]
                             && (!stby_reg[2] || !stby_reg[1] || !stby_reg[3]
                                 || (!stby_reg[6] && !stby_reg[0]));
            headphone_route <= !stby_reg[9] && !stby_reg[8] && !stby_reg[6] && !stby_reg[5];
            line_out_route  <= !stby_reg[9] && !stby_reg[8] && !stby_reg[6] && stby_reg[5];
        end
    end

    sync_one_cycle_a: assert property (@(posedge pclk) disable iff (!presetn)
        dac_frame_sync_pulse |=> !dac_frame_sync_pulse) else $error("frame sync longer than one cycle");
    sync_period_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(adc_frame_sync_pulse) |-> ##64 adc_frame_sync_pulse) else $error("frame period wrong");
    mute_enter_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mute_state == ACDC_NORMAL && mute_sync[2]) |=> mute_state == ACDC_DOWN) else $error("mute not entered");
    muted_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mute_state == ACDC_MUTED) |=> digital_gain_stage == 16'h0000) else $error("muted gain not zero");
    unmute_ramp_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mute_state == ACDC_MUTED && !mute_sync[2]) |=> mute_state == ACDC_UP) else $error("unmute ramp missed");
    flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        unst_sync[1] |=> tcb_reg[0]) else $error("instability event lost");
    couple_right_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ogl_reg[7:6] == 2'b01) |=> eff_left_gain == $past(ogr_reg[4:0])) else $error("right coupling wrong");
    powerdown_a: assert property (@(posedge pclk) disable iff (!presetn)
        stby_reg[9] |=> (power_down && !sleep_mode && !record_ok)) else $error("master standby ignored");
    unused_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        ogl_reg[5] == 1'b0 && ogr_reg[7:5] == 3'b000) else $error("unused bits set");

    // Bus answer: one ready pulse per setup cycle, and an error only alongside it.
    pready_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready) else $error("setup not answered");
    pready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready) else $error("ready held too long");
    slverr_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready) else $error("error without ready");

    // Framing, the instability flag and the test-control bits.
    sync_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
        adc_frame_sync_pulse == dac_frame_sync_pulse) else $error("frame syncs apart");
    data_after_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
        dac_frame_sync_pulse |=> dac_serial_audio_line == $past(tx_shift[47])) else $error("first bit late");
    flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && pready && pstrb[0] && paddr == `ACDC_OFF_TCB && !pwdata[0] && !unst_sync[1]) |=> !tcb_reg[0])
        else $error("flag not cleared");
    test_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && pready && pstrb[0] && paddr == `ACDC_OFF_TCB) |=> tcb_reg[7:1] == $past(pwdata[7:1]))
        else $error("test bits not written");

    // Decoding, coupling and ramp behaviour follow their registers one cycle later.
    sleep_decode_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!stby_reg[9] && stby_reg[8]) |=> (sleep_mode && !power_down && clock_stop_ok)) else $error("sleep wrong");
    clock_run_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!stby_reg[9] && !stby_reg[8]) |=> !clock_stop_ok) else $error("clock stop allowed while running");
    route_single_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(headphone_route && line_out_route)) else $error("both outputs routed");
    headphone_on_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!stby_reg[9] && !stby_reg[8] && !stby_reg[6] && !stby_reg[5]) |=> headphone_route)
        else $error("headphone not routed");
    record_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        (stby_reg[9] || stby_reg[8] || stby_reg[4]) |=> !record_ok) else $error("record while off");
    record_line_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!stby_reg[9] && !stby_reg[8] && !stby_reg[4] && !stby_reg[2]) |=> record_ok) else $error("line record lost");
    couple_left_a: assert property (@(posedge pclk) disable iff (!presetn)
        ogl_reg[7] |=> eff_right_gain == $past(ogl_reg[4:0])) else $error("left coupling wrong");
    gains_apart_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ogl_reg[7:6] == 2'b00) |=> (eff_left_gain == $past(ogl_reg[4:0])
                                     && eff_right_gain == $past(ogr_reg[4:0]))) else $error("gains not independent");
    down_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mute_state == ACDC_DOWN && ramp_cnt >= RAMP_CYCLES - 1) |=> mute_state == ACDC_MUTED)
        else $error("ramp down too long");
    gain_falls_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mute_state == ACDC_DOWN) |=> digital_gain_stage <= $past(digital_gain_stage)) else $error("gain rose in ramp down");
    gain_rises_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mute_state == ACDC_UP) |=> digital_gain_stage >= $past(digital_gain_stage)) else $error("gain fell in ramp up");
    up_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mute_state == ACDC_UP && ramp_cnt >= RAMP_CYCLES - 1) |=> mute_state == ACDC_NORMAL)
        else $error("ramp up too long");
    unity_normal_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mute_state == ACDC_NORMAL) |=> digital_gain_stage == GAIN_MAX) else $error("normal gain not unity");
endmodule : acdc_top

//--- acdc_host_model.sv
// Host audio controller model that sends one ADC frame after every ADC frame sync.
// Assumes the frame sync is a registered one-cycle pulse on pclk.
`timescale 1ns/1ps
module acdc_host_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        adc_frame_sync_pulse,
    input  wire logic [23:0] left,
    input  wire logic [23:0] right,
    input  wire logic [4:0]  wbits,
    output logic             adc_serial_audio_line_in
);
    int n;
    // Outside the words the line toggles, so a stale bit can never pass for data.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            n <= 0;
            adc_serial_audio_line_in <= 1'b0;
        end else if (adc_frame_sync_pulse) begin
            n <= 1;
            adc_serial_audio_line_in <= left[wbits-1];
        end else if (n > 0 && n < 2 * wbits) begin
            n <= n + 1;
            adc_serial_audio_line_in <= (n < wbits) ? left[wbits-1-n] : right[2*wbits-1-n];
        end else begin
            n <= 0;
            adc_serial_audio_line_in <= ~adc_serial_audio_line_in;
        end
    end
endmodule : acdc_host_model

//--- acdc_top_tb.sv
// Self-checking bench for the codec digital control.
// Assumes acdc_top with a 16-cycle mute ramp and the host model on the ADC line.
`timescale 1ns/1ps
`include "acdc_defs.svh"
module acdc_top_tb;
    import acdc_pkg::*;
    typedef struct {logic w; logic [11:0] a; logic [11:0] d; logic [11:0] e;} acdc_row_t;
    logic        pclk, presetn, psel, penable, pwrite, mute_in, adc_instability_in;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, err, dsync, dline, async, adc_serial_audio_line_in;
    logic [4:0]  eff_l, eff_r;
    logic [15:0] gain;
    wire  [5:0]  dec;
    int          n_mismatch, compares, n;
    acdc_row_t   rows[14] = '{
        '{0, `ACDC_OFF_OGL, 12'h0, 12'h0A}, '{0, `ACDC_OFF_OGR, 12'h0, 12'h0A},
        '{0, `ACDC_OFF_AIG, 12'h0, 12'h00}, '{0, `ACDC_OFF_TCA, 12'h0, 12'h00},
        '{0, `ACDC_OFF_TCB, 12'h0, 12'hD8}, '{0, `ACDC_OFF_STBY, 12'h0, 12'h0B1},
        '{1, `ACDC_OFF_OGL, 12'hFF, 12'hDF}, '{1, `ACDC_OFF_OGR, 12'hFF, 12'h1F},
        '{1, `ACDC_OFF_AIG, 12'hA5, 12'hA5}, '{1, `ACDC_OFF_TCA, 12'hFF, 12'hFF},
        '{1, `ACDC_OFF_TCB, 12'h7E, 12'h7E}, '{1, `ACDC_OFF_TCB, 12'hD8, 12'hD8},
        '{1, `ACDC_OFF_STBY, 12'h3FF, 12'h3FF}, '{1, `ACDC_OFF_OGL, 12'h0A, 12'h0A}};
    logic [9:0]  sv[9] = '{10'h200, 10'h100, 10'h300, 10'h000, 10'h020, 10'h0CD, 10'h0DD, 10'h00E, 10'h04E};
    logic [5:0]  se[9] = '{6'h21, 6'h11, 6'h21, 6'h0C, 6'h0A, 6'h08, 6'h00, 6'h0C, 6'h00};

    acdc_top #(.RAMP_CYCLES(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mute_in(mute_in), .adc_instability_in(adc_instability_in),
        .adc_serial_audio_line_in(adc_serial_audio_line_in), .dac_frame_sync_pulse(dsync), .dac_serial_audio_line(dline),
        .adc_frame_sync_pulse(async), .eff_left_gain(eff_l), .eff_right_gain(eff_r),
        .digital_gain_stage(gain), .power_down(dec[5]), .sleep_mode(dec[4]), .record_ok(dec[3]),
        .headphone_route(dec[2]), .line_out_route(dec[1]), .clock_stop_ok(dec[0]));
    acdc_host_model host (.pclk(pclk), .presetn(presetn), .adc_frame_sync_pulse(async),
        .left(24'h123456), .right(24'hABCDEF), .wbits(5'h18), .adc_serial_audio_line_in(adc_serial_audio_line_in));

    task automatic end_sim;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) n_mismatch++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wsync;
        int k;
        k = 0;
        do begin
            @(negedge pclk);
            k++;
        end while (dsync !== 1'b1 && k < 200);
        if (k >= 200) n_mismatch++;
    endtask : wsync

    // The first sync may belong to a frame latched before the last write, so it is skipped.
    task automatic frame(input logic [63:0] exp);
        logic [63:0] d, s, a;
        wsync;
        wsync;
        for (int i = 63; i >= 0; i--) begin
            d[i] = dline;
            s[i] = dsync;
            a[i] = async;
            @(negedge pclk);
        end
        chk(d, exp);
        chk({s[62:0], dsync}, 64'h1);
        chk(64'($countones(a)), 64'h1);
    endtask : frame

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    initial begin
        #200000;
        n_mismatch++;
        end_sim;
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        mute_in = 1'b0;
        adc_instability_in = 1'b0;
        n_mismatch = 0;
        compares = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk({eff_l, eff_r, gain}, {5'h0A, 5'h0A, 16'hFFFF});
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, 32'(rows[i].d));
            apb(1'b0, rows[i].a, 32'h0);
            chk(64'(rd), 64'(rows[i].e));
        end
        apb(1'b0, 12'h040, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, `ACDC_OFF_OGR, 32'h1A);
            apb(1'b1, `ACDC_OFF_OGL, 32'((c << 6) | 5));
            repeat (2) @(negedge pclk);
            chk({eff_l, eff_r}, {(c == 1) ? 5'h1A : 5'h05, (c < 2) ? 5'h1A : 5'h05});
        end
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `ACDC_OFF_OGL, 32'h0);
        chk(64'(rd), 64'h0A);
        foreach (sv[i]) begin
            apb(1'b1, `ACDC_OFF_STBY, 32'(sv[i]));
            repeat (2) @(negedge pclk);
            chk(64'(dec), 64'(se[i]));
        end
        adc_instability_in <= 1'b1;
        repeat (3) @(posedge pclk);
        adc_instability_in <= 1'b0;
        repeat (4) @(posedge pclk);
        for (int v = 'hD9; v >= 'hD8; v--) begin
            apb(1'b1, `ACDC_OFF_TCB, 32'(v));
            apb(1'b0, `ACDC_OFF_TCB, 32'h0);
            chk(64'(rd), 64'(v));
        end
        apb(1'b1, `ACDC_OFF_DACL, 32'hFFFFFF);
        apb(1'b1, `ACDC_OFF_DACR, 32'hFFFFFF);
        for (int w = 0; w < 4; w++) begin
            apb(1'b1, `ACDC_OFF_AUDIO, 32'(w));
            n = (w == 3) ? 24 : 16 + 2 * w;
            frame(~(64'hFFFFFFFFFFFFFFFF >> (2 * n)) >> 1);
        end
        apb(1'b1, `ACDC_OFF_DACL, 32'hA5C3F1);
        apb(1'b1, `ACDC_OFF_DACR, 32'h3C5A0F);
        frame({1'b0, 24'hA5C3F1, 24'h3C5A0F, 15'h0});
        apb(1'b0, `ACDC_OFF_ADCL, 32'h0);
        chk(64'(rd), 64'h123456);
        apb(1'b0, `ACDC_OFF_ADCR, 32'h0);
        chk(64'(rd), 64'hABCDEF);
        for (int m = 1; m >= 0; m--) begin
            @(posedge pclk);
            mute_in <= m[0];
            n = 0;
            do begin
                @(negedge pclk);
                n++;
            end while (gain !== (m[0] ? 16'h0 : 16'hFFFF) && n < 60);
            chk(64'(n >= 16 && n <= 24), 64'h1);
            apb(1'b0, `ACDC_OFF_STATUS, 32'h0);
            chk(64'(rd[3:1]), m[0] ? 64'h7 : 64'h0);
            if (m[0]) frame(64'h0);
        end
        end_sim;
    end
endmodule : acdc_top_tb
